// file: logic/cosl_unit.sv
/*
   Combine-or / element-select logic unit: one-cycle bitwise datapath fed by
   the instruction decoder, plus a Wishbone register window for software.
   Assumes decoder, register file and bus master all run on clk_sys.
*/
// The register offsets and register access over Wishbone were decided locally.
// Behaviour
// - Combine-or applies the two-input function, then ORs all bits per element.
// - Function code 000..111 selects and, andn, xor, or, nor, xnor, orn, nand.
// - Two-bit size field selects the element width of the combine-or.
// - Combine-or with SIMD flag set works on every element; clear works on the low one.
// - Select takes the first operand where the selector element is all ones.
// - Both operations finish in one cycle, one accepted every cycle.
`timescale 1ns/1ps
`include "cosl_consts.svh"

module cosl_unit #(
   parameter int AW = 8
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire cosl_pkg::cosl_issue_t issue,
   output cosl_pkg::cosl_result_t     result,
   input  wire logic                  wb_cyc,
   input  wire logic                  wb_stb,
   input  wire logic                  wb_we,
   input  wire logic [AW-1:0]         wb_adr,
   input  wire logic [3:0]            wb_sel,
   input  wire logic [31:0]           wb_dat_wr,
   output logic      [31:0]           wb_dat_rd,
   output logic                       wb_ack
);

   localparam int NBYTES = `COSL_DATA_W / 8;

   cosl_pkg::cosl_issue_t    sw_cmd;
   cosl_pkg::cosl_issue_t    sel_op;
   logic                     sw_taken;
   logic                     op_go;

   logic [1:0]               op_size;
   logic                     op_simd;
   logic [2:0]               op_code;

   logic [`COSL_DATA_W-1:0]  func;
   logic [`COSL_DATA_W-1:0]  nxt_data;

   logic                     res_valid_ff;
   logic [`COSL_DATA_W-1:0]  res_data_ff;
   logic                     sw_tag_ff;

   // ========================================================================
   // Software register window
   // ========================================================================
   cosl_wb_regs #(
      .AW (AW)
   ) u_regs (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .wb_cyc    (wb_cyc),
      .wb_stb    (wb_stb),
      .wb_we     (wb_we),
      .wb_adr    (wb_adr),
      .wb_sel    (wb_sel),
      .wb_dat_wr (wb_dat_wr),
      .wb_dat_rd (wb_dat_rd),
      .wb_ack    (wb_ack),
      .sw_cmd    (sw_cmd),
      .sw_taken  (sw_taken),
      .sw_done   (sw_tag_ff),
      .sw_data   (res_data_ff)
   );

   // ========================================================================
   // Issue arbitration
   // ========================================================================
   // The decoder always wins: stalling the pipeline for a debug-style software
   // operation would cost throughput, so software simply waits for a gap.
   assign sw_taken = sw_cmd.valid & ~issue.valid;
   assign sel_op   = issue.valid ? issue : sw_cmd;
   assign op_go    = issue.valid | sw_cmd.valid;
   assign op_size  = sel_op.flags[`COSL_FLG_SIZE_HI:`COSL_FLG_SIZE_LO];
   assign op_simd  = sel_op.flags[`COSL_FLG_SIMD];
   assign op_code  = sel_op.flags[`COSL_FLG_OP_HI:`COSL_FLG_OP_LO];

   // ========================================================================
   // Two-input bitwise function
   // ========================================================================
   always_comb begin
      case (op_code)
         `COSL_OP_AND:  func = sel_op.src_a & sel_op.src_b;
         `COSL_OP_ANDN: func = sel_op.src_a & ~sel_op.src_b;
         `COSL_OP_XOR:  func = sel_op.src_a ^ sel_op.src_b;
         `COSL_OP_OR:   func = sel_op.src_a | sel_op.src_b;
         `COSL_OP_NOR:  func = ~(sel_op.src_a | sel_op.src_b);
         `COSL_OP_XNOR: func = ~(sel_op.src_a ^ sel_op.src_b);
         `COSL_OP_ORN:  func = sel_op.src_a | ~sel_op.src_b;
         default:       func = ~(sel_op.src_a & sel_op.src_b);
      endcase
   end

   // ========================================================================
   // Per-byte element reduction and selection
   // ========================================================================
   // Every byte looks at all bytes of its own element, so each element size
   // is the same small OR/AND tree rather than a separate datapath.
   genvar k;
   generate
      for (k = 0; k < NBYTES; k++) begin : g_byte
         logic       any_v;
         logic       all_v;
         logic [7:0] byte_v;

         always_comb begin
            any_v = 1'b0;
            all_v = 1'b1;
            for (int j = 0; j < NBYTES; j++) begin
               if ((j >> op_size) == (k >> op_size)) begin
                  any_v = any_v | (|func[8*j +: 8]);
                  all_v = all_v & (&sel_op.src_b[8*j +: 8]);
               end
            end
         end

         // Select ignores the SIMD and function fields, which are reserved for it.
         always_comb begin
            if (sel_op.is_select) begin
               byte_v = all_v ? sel_op.src_a[8*k +: 8] : sel_op.dst[8*k +: 8];
            end else if (!op_simd && (k >> op_size) != 0) begin
               byte_v = 8'h00;
            end else begin
               byte_v = {8{any_v}};
            end
         end

         assign nxt_data[8*k +: 8] = byte_v;
      end
   endgenerate

   // ========================================================================
   // Result stage
   // ========================================================================
   // One register stage only: a new operation is accepted on every edge.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         res_valid_ff <= 1'b0;
         sw_tag_ff    <= 1'b0;
      end else begin
         res_valid_ff <= issue.valid;
         sw_tag_ff    <= sw_taken;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         res_data_ff <= 64'h0000_0000_0000_0000;
      end else if (op_go) begin
         res_data_ff <= nxt_data;
      end
   end

   assign result.valid = res_valid_ff;
   assign result.data  = res_data_ff;

   // ========================================================================
   // Checks
   // ========================================================================
   logic byte_clean;

   always_comb begin
      byte_clean = 1'b1;
      for (int i = 0; i < NBYTES; i++) begin
         if (res_data_ff[8*i +: 8] != 8'h00 && res_data_ff[8*i +: 8] != 8'hFF) begin
            byte_clean = 1'b0;
         end
      end
   end

   sequence s_cor(logic [1:0] sz, logic simd, logic [2:0] code);
      op_go && !sel_op.is_select && op_size == sz && op_simd == simd && op_code == code;
   endsequence

   sequence s_sel_byte;
      op_go && sel_op.is_select && op_size == `COSL_SIZE_B;
   endsequence

   sequence s_sel_quad;
      op_go && sel_op.is_select && op_size == `COSL_SIZE_D;
   endsequence

   property p_cor_byte_or;
      @(posedge clk_sys) disable iff (rst)
      s_cor(`COSL_SIZE_B, 1'b1, `COSL_OP_OR) |=>
         res_data_ff[15:0] == {{8{|($past(sel_op.src_a[15:8]) | $past(sel_op.src_b[15:8]))}},
                               {8{|($past(sel_op.src_a[7:0]) | $past(sel_op.src_b[7:0]))}}};
   endproperty
   a_cor_byte_or: assert property (p_cor_byte_or)
      else $error("combine-or byte result does not match OR of operands");

   property p_xor_quad;
      @(posedge clk_sys) disable iff (rst)
      s_cor(`COSL_SIZE_D, 1'b1, `COSL_OP_XOR) |=>
         res_data_ff == {64{|($past(sel_op.src_a) ^ $past(sel_op.src_b))}};
   endproperty
   a_xor_quad: assert property (p_xor_quad)
      else $error("combine-or xor on 64-bit element is wrong");

   property p_andn_half;
      @(posedge clk_sys) disable iff (rst)
      s_cor(`COSL_SIZE_H, 1'b1, `COSL_OP_ANDN) |=>
         res_data_ff[31:16] == {16{|($past(sel_op.src_a[31:16]) & ~$past(sel_op.src_b[31:16]))}};
   endproperty
   a_andn_half: assert property (p_andn_half)
      else $error("combine-or andn on 16-bit element is wrong");

   property p_scalar_low_only;
      @(posedge clk_sys) disable iff (rst)
      (op_go && !sel_op.is_select && !op_simd && op_size == `COSL_SIZE_W) |=>
         res_data_ff[63:32] == 32'h0000_0000;
   endproperty
   a_scalar_low_only: assert property (p_scalar_low_only)
      else $error("non-SIMD combine-or touched upper elements");

   property p_select_byte;
      @(posedge clk_sys) disable iff (rst)
      s_sel_byte |=> res_data_ff[7:0] == (($past(sel_op.src_b[7:0]) == 8'hFF) ?
                                          $past(sel_op.src_a[7:0]) : $past(sel_op.dst[7:0]));
   endproperty
   a_select_byte: assert property (p_select_byte)
      else $error("select chose the wrong byte");

   sequence s_issue_pair;
      issue.valid ##1 issue.valid;
   endsequence

   sequence s_result_pair;
      res_valid_ff ##1 res_valid_ff;
   endsequence

   property p_one_cycle;
      @(posedge clk_sys) disable iff (rst)
      s_issue_pair |-> s_result_pair;
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("back-to-back issues did not give back-to-back results");

   property p_no_spurious;
      @(posedge clk_sys) disable iff (rst)
      !issue.valid |=> !res_valid_ff;
   endproperty
   a_no_spurious: assert property (p_no_spurious)
      else $error("result valid without an issue one cycle before");

   property p_full_mask;
      @(posedge clk_sys) disable iff (rst)
      (op_go && !sel_op.is_select) |=> byte_clean;
   endproperty
   a_full_mask: assert property (p_full_mask)
      else $error("combine-or byte is neither all zeros nor all ones");

   property p_select_quad;
      @(posedge clk_sys) disable iff (rst)
      s_sel_quad |=> res_data_ff == (&$past(sel_op.src_b) ? $past(sel_op.src_a)
                                                           : $past(sel_op.dst));
   endproperty
   a_select_quad: assert property (p_select_quad)
      else $error("select on 64-bit element chose the wrong word");

   property p_nor_byte_scalar;
      @(posedge clk_sys) disable iff (rst)
      s_cor(`COSL_SIZE_B, 1'b0, `COSL_OP_NOR) |=>
         res_data_ff == {56'h00_0000_0000_0000,
                         {8{~&$past(sel_op.src_a[7:0] | sel_op.src_b[7:0])}}};
   endproperty
   a_nor_byte_scalar: assert property (p_nor_byte_scalar)
      else $error("non-SIMD combine-or nor on byte is wrong");

   property p_orn_word;
      @(posedge clk_sys) disable iff (rst)
      s_cor(`COSL_SIZE_W, 1'b1, `COSL_OP_ORN) |=>
         res_data_ff[63:32] == {32{|$past(sel_op.src_a[63:32] | ~sel_op.src_b[63:32])}};
   endproperty
   a_orn_word: assert property (p_orn_word)
      else $error("combine-or orn on upper word is wrong");

   property p_and_byte_top;
      @(posedge clk_sys) disable iff (rst)
      s_cor(`COSL_SIZE_B, 1'b1, `COSL_OP_AND) |=>
         res_data_ff[63:56] == {8{|$past(sel_op.src_a[63:56] & sel_op.src_b[63:56])}};
   endproperty
   a_and_byte_top: assert property (p_and_byte_top)
      else $error("combine-or and on top byte is wrong");

   property p_data_hold;
      @(posedge clk_sys) disable iff (rst)
      !op_go |=> $stable(res_data_ff);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("result changed without an operation");

   property p_nand_quad_scalar;
      @(posedge clk_sys) disable iff (rst)
      s_cor(`COSL_SIZE_D, 1'b0, `COSL_OP_NAND) |=>
         res_data_ff == {64{~&$past(sel_op.src_a & sel_op.src_b)}};
   endproperty
   a_nand_quad_scalar: assert property (p_nand_quad_scalar)
      else $error("combine-or nand on 64-bit element is wrong");

endmodule

// file: logic/cosl_consts.svh
/*
   Constants of the combine-or / select logic unit: field positions, operation
   codes, register offsets, reset values and timing counts.
   Assumes it is included by bare name from the package and the design files.
*/
`ifndef COSL_CONSTS_SVH
`define COSL_CONSTS_SVH

// ==========================================================================
// Datapath and flag field layout
// ==========================================================================
`define COSL_DATA_W        64
`define COSL_FLAGS_W       6
`define COSL_FLG_SIZE_HI   5
`define COSL_FLG_SIZE_LO   4
`define COSL_FLG_SIMD      3
`define COSL_FLG_OP_HI     2
`define COSL_FLG_OP_LO     0

// ==========================================================================
// Two-input function codes
// ==========================================================================
`define COSL_OP_AND        3'h0
`define COSL_OP_ANDN       3'h1
`define COSL_OP_XOR        3'h2
`define COSL_OP_OR         3'h3
`define COSL_OP_NOR        3'h4
`define COSL_OP_XNOR       3'h5
`define COSL_OP_ORN        3'h6
`define COSL_OP_NAND       3'h7

// ==========================================================================
// Element size codes (log2 of the element width in bytes)
// ==========================================================================
`define COSL_SIZE_B        2'h0
`define COSL_SIZE_H        2'h1
`define COSL_SIZE_W        2'h2
`define COSL_SIZE_D        2'h3

// ==========================================================================
// Register map, byte addresses
// ==========================================================================
`define COSL_ADR_CTRL      8'h00
`define COSL_ADR_STATUS    8'h04
`define COSL_ADR_A_LO      8'h08
`define COSL_ADR_A_HI      8'h0C
`define COSL_ADR_B_LO      8'h10
`define COSL_ADR_B_HI      8'h14
`define COSL_ADR_D_LO      8'h18
`define COSL_ADR_D_HI      8'h1C
`define COSL_ADR_RES_LO    8'h20
`define COSL_ADR_RES_HI    8'h24

`define COSL_CTRL_START    31
`define COSL_CTRL_KIND     8
`define COSL_STAT_BUSY     0
`define COSL_STAT_DONE     1
`define COSL_CTRL_RST      7'h00

// ==========================================================================
// Timing
// ==========================================================================
`define COSL_LATENCY       1

`endif

// file: logic/cosl_pkg.sv
/*
   Types of the combine-or / select logic unit: the issue bundle sent by the
   decoder and the result bundle returned to the register file.
   Assumes cosl_consts.svh is on the include path.
*/
`include "cosl_consts.svh"

package cosl_pkg;

   // =======================================================================
   // Issue and result bundles
   // =======================================================================
   typedef struct packed {
      logic                      valid;
      logic                      is_select;
      logic [`COSL_FLAGS_W-1:0]  flags;
      logic [`COSL_DATA_W-1:0]   src_a;
      logic [`COSL_DATA_W-1:0]   src_b;
      logic [`COSL_DATA_W-1:0]   dst;
   } cosl_issue_t;

   typedef struct packed {
      logic                      valid;
      logic [`COSL_DATA_W-1:0]   data;
   } cosl_result_t;

endpackage

// file: logic/cosl_wb_regs.sv
/*
   Wishbone classic slave holding the software view of the logic unit:
   control, status, operand and result registers.
   Assumes a single clock domain and a master that holds each request until ack.
*/
`timescale 1ns/1ps
`include "cosl_consts.svh"

module cosl_wb_regs #(
   parameter int AW = 8
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  wb_cyc,
   input  wire logic                  wb_stb,
   input  wire logic                  wb_we,
   input  wire logic [AW-1:0]         wb_adr,
   input  wire logic [3:0]            wb_sel,
   input  wire logic [31:0]           wb_dat_wr,
   output logic      [31:0]           wb_dat_rd,
   output logic                       wb_ack,
   output cosl_pkg::cosl_issue_t      sw_cmd,
   input  wire logic                  sw_taken,
   input  wire logic                  sw_done,
   input  wire logic [`COSL_DATA_W-1:0] sw_data
);

   logic                       ack_ff;
   logic [31:0]                rdat_ff;
   logic [6:0]                 ctrl_ff;
   logic [`COSL_DATA_W-1:0]    opa_ff;
   logic [`COSL_DATA_W-1:0]    opb_ff;
   logic [`COSL_DATA_W-1:0]    opd_ff;
   logic [`COSL_DATA_W-1:0]    res_ff;
   logic                       pend_ff;
   logic                       fly_ff;
   logic                       done_ff;
   logic                       req;
   logic                       wr;
   logic [7:0]                 adr;
   logic                       busy;

   assign req  = wb_cyc & wb_stb & ~ack_ff;
   assign wr   = req & wb_we;
   assign adr  = 8'(wb_adr);
   assign busy = pend_ff | fly_ff;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  lanes);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (lanes[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ========================================================================
   // Bus handshake
   // ========================================================================
   // Ack rises one cycle after the request and drops the cycle after, so a
   // held request is never taken twice.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdat_ff <= 32'h0000_0000;
      end else if (req & ~wb_we) begin
         case (adr)
            `COSL_ADR_CTRL:   rdat_ff <= {23'h00_0000, ctrl_ff[6], 2'h0, ctrl_ff[5:0]};
            `COSL_ADR_STATUS: rdat_ff <= {30'h0000_0000, done_ff, busy};
            `COSL_ADR_A_LO:   rdat_ff <= opa_ff[31:0];
            `COSL_ADR_A_HI:   rdat_ff <= opa_ff[63:32];
            `COSL_ADR_B_LO:   rdat_ff <= opb_ff[31:0];
            `COSL_ADR_B_HI:   rdat_ff <= opb_ff[63:32];
            `COSL_ADR_D_LO:   rdat_ff <= opd_ff[31:0];
            `COSL_ADR_D_HI:   rdat_ff <= opd_ff[63:32];
            `COSL_ADR_RES_LO: rdat_ff <= res_ff[31:0];
            `COSL_ADR_RES_HI: rdat_ff <= res_ff[63:32];
            default:          rdat_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ========================================================================
   // Operand and control registers
   // ========================================================================
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_ff <= `COSL_CTRL_RST;
         opa_ff  <= 64'h0000_0000_0000_0000;
         opb_ff  <= 64'h0000_0000_0000_0000;
         opd_ff  <= 64'h0000_0000_0000_0000;
      end else if (wr) begin
         case (adr)
            `COSL_ADR_CTRL: begin
               if (wb_sel[0]) begin
                  ctrl_ff[5:0] <= wb_dat_wr[5:0];
               end
               if (wb_sel[1]) begin
                  ctrl_ff[6] <= wb_dat_wr[`COSL_CTRL_KIND];
               end
            end
            `COSL_ADR_A_LO: opa_ff[31:0]  <= merge(opa_ff[31:0], wb_dat_wr, wb_sel);
            `COSL_ADR_A_HI: opa_ff[63:32] <= merge(opa_ff[63:32], wb_dat_wr, wb_sel);
            `COSL_ADR_B_LO: opb_ff[31:0]  <= merge(opb_ff[31:0], wb_dat_wr, wb_sel);
            `COSL_ADR_B_HI: opb_ff[63:32] <= merge(opb_ff[63:32], wb_dat_wr, wb_sel);
            `COSL_ADR_D_LO: opd_ff[31:0]  <= merge(opd_ff[31:0], wb_dat_wr, wb_sel);
            `COSL_ADR_D_HI: opd_ff[63:32] <= merge(opd_ff[63:32], wb_dat_wr, wb_sel);
            default: begin
            end
         endcase
      end
   end

   // ========================================================================
   // Software-started operation tracking
   // ========================================================================
   // A start while busy is dropped; operands may change under a pending op.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pend_ff <= 1'b0;
         fly_ff  <= 1'b0;
      end else begin
         fly_ff <= sw_taken;
         if (wr && adr == `COSL_ADR_CTRL && wb_sel[3] && wb_dat_wr[`COSL_CTRL_START]
             && !busy) begin
            pend_ff <= 1'b1;
         end else if (sw_taken) begin
            pend_ff <= 1'b0;
         end
      end
   end

   // The completion flag is sticky; a completion in the clearing cycle wins.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         done_ff <= 1'b0;
         res_ff  <= 64'h0000_0000_0000_0000;
      end else begin
         done_ff <= sw_done | (done_ff & ~(wr && adr == `COSL_ADR_STATUS && wb_sel[0]
                                           && wb_dat_wr[`COSL_STAT_DONE]));
         if (sw_done) begin
            res_ff <= sw_data;
         end
      end
   end

   assign wb_ack           = ack_ff;
   assign wb_dat_rd        = rdat_ff;
   assign sw_cmd.valid     = pend_ff;
   assign sw_cmd.is_select = ctrl_ff[6];
   assign sw_cmd.flags     = ctrl_ff[5:0];
   assign sw_cmd.src_a     = opa_ff;
   assign sw_cmd.src_b     = opb_ff;
   assign sw_cmd.dst       = opd_ff;

endmodule

// file: verification/cosl_dec_model.sv
/*
   Decoder model: drives one issue bundle per call into the logic unit.
   Assumes the caller waits for reset release before the first call.
*/
`timescale 1ns/1ps

module cosl_dec_model (
   input  wire logic             clk_sys,
   output cosl_pkg::cosl_issue_t issue
);
   // ======================================================================
   // Issue driving
   // ======================================================================
   initial issue = '0;

   task automatic send(input logic sel, input logic [5:0] f, input logic [63:0] a, b, d);
      @(posedge clk_sys);
      issue <= '{valid: 1'b1, is_select: sel, flags: sel ? {f[5:4], 4'h0} : f,
                 src_a: a, src_b: b, dst: d};
   endtask

   // Idle operands are scrambled so a stale value never passes for a live one.
   task automatic idle();
      @(posedge clk_sys);
      issue <= '{valid: 1'b0, is_select: ~issue.is_select, flags: ~issue.flags,
                 src_a: ~issue.src_a, src_b: ~issue.src_b, dst: ~issue.dst};
   endtask
endmodule

// file: verification/cosl_unit_tb_top.sv
/*
   Self-checking bench of the logic unit: decoder issues and bus accesses.
   Assumes the decoder model file is compiled before this one.
*/
`timescale 1ns/1ps

module cosl_unit_tb_top;
   logic                   clk_sys;
   logic                   rst;
   cosl_pkg::cosl_issue_t  issue;
   cosl_pkg::cosl_result_t result;
   logic                   wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0]             wb_adr;
   logic [3:0]             wb_sel;
   logic [31:0]            wb_dat_wr, wb_dat_rd, rd;
   int                     error_cnt, checks, cyc;
   logic [63:0]            exp_q[$];
   int                     due_q[$];
   logic [63:0]            pa[2] = '{64'h0000_ff00_0f0f_0001, 64'hffff_0000_ff00_8000};
   logic [63:0]            pb[2] = '{64'h00ff_ff00_f0f0_0001, 64'hffff_ffff_00ff_0000};

   cosl_unit uut (.clk_sys(clk_sys), .rst(rst), .issue(issue), .result(result),
                  .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
                  .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd),
                  .wb_ack(wb_ack));
   cosl_dec_model dec (.clk_sys(clk_sys), .issue(issue));

   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;
   always @(negedge clk_sys) cyc++;

   // ======================================================================
   // Reporting and reference
   // ======================================================================
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   function automatic logic [63:0] ref_op(input logic sel, input logic [5:0] f,
                                          input logic [63:0] a, b, d);
      int          w;
      logic [63:0] t, m, r;
      w = 8 << f[5:4];
      r = '0;
      case (f[2:0])
         3'h0: t = a & b;
         3'h1: t = a & ~b;
         3'h2: t = a ^ b;
         3'h3: t = a | b;
         3'h4: t = ~(a | b);
         3'h5: t = ~(a ^ b);
         3'h6: t = a | ~b;
         default: t = ~(a & b);
      endcase
      for (int e = 0; e < 64 / w; e++) begin
         m = ((64'h1 << w) - 64'h1) << (e * w);
         if (sel) r = r | (((b & m) == m) ? (a & m) : (d & m));
         else if ((f[3] || e == 0) && |(t & m)) r = r | m;
      end
      return r;
   endfunction

   // Every result pulse must match the oldest outstanding issue, two edges on.
   always @(posedge clk_sys) begin
      if (rst === 1'b0 && result.valid !== 1'b0) begin
         if (exp_q.size() == 0) begin
            chk("unexpected result valid", 64'(result.valid), 64'h0);
         end else begin
            chk("result latency", 64'(cyc), 64'(due_q.pop_front()));
            chk("result data", result.data, exp_q.pop_front());
         end
      end
   end

   // ======================================================================
   // Access tasks
   // ======================================================================
   task automatic op(input logic sel, input logic [5:0] f, input logic [63:0] a, b, d);
      dec.send(sel, f, a, b, d);
      exp_q.push_back(ref_op(sel, f, a, b, d));
      due_q.push_back(cyc + 2);
   endtask

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= 4'hf;
      wb_dat_wr <= wd;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (n >= 20) chk("bus ack", 64'h0, 64'h1);
      rdat = wb_dat_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic sw_op(input logic sel, input logic [5:0] f, input logic [63:0] a, b, d);
      logic [63:0] v[3];
      logic [63:0] r;
      int          n;
      v = '{a, b, d};
      for (int k = 0; k < 3; k++) begin
         wb(1'b1, 8'(8 + 8 * k), v[k][31:0], rd);
         wb(1'b1, 8'(12 + 8 * k), v[k][63:32], rd);
      end
      wb(1'b1, 8'h00, {1'b1, 22'h0, sel, 2'h0, f}, rd);
      n = 0;
      do begin
         wb(1'b0, 8'h04, 32'h0, rd);
         n++;
      end while (rd[1] !== 1'b1 && n < 20);
      chk("done flag", 64'(rd[1]), 64'h1);
      wb(1'b0, 8'h20, 32'h0, r[31:0]);
      wb(1'b1, 8'h24, 32'h5a5a_5a5a, rd);
      wb(1'b0, 8'h24, 32'h0, r[63:32]);
      chk("software result", r, ref_op(sel, f, a, b, d));
      wb(1'b1, 8'h04, 32'h2, rd);
      wb(1'b0, 8'h04, 32'h0, rd);
      chk("status after clear", 64'(rd), 64'h0);
   endtask

   // ======================================================================
   // Test sequence
   // ======================================================================
   initial begin
      error_cnt = 0;
      checks = 0;
      cyc = 0;
      rst = 1'b1;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_wr} = '0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      wb(1'b0, 8'h04, 32'h0, rd);
      chk("status after reset", 64'(rd), 64'h0);
      for (int p = 0; p < 2; p++) begin
         for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 16; m++) begin
               op(1'b0, {2'(s), 4'(m)}, pa[p], pb[p], 64'h0);
            end
            op(1'b1, {2'(s), 4'h0}, pa[p], {pb[p][31:0], pa[p][63:32]},
               64'h1234_5678_9abc_def0);
         end
      end
      dec.idle();
      repeat (3) @(posedge clk_sys);
      chk("results outstanding", 64'(exp_q.size()), 64'h0);
      sw_op(1'b0, 6'h1a, pa[0], pb[1], 64'h0);
      sw_op(1'b1, 6'h10, pa[1], pb[1], 64'h0f0f_0f0f_0f0f_0f0f);
      wb(1'b0, 8'h40, 32'h0, rd);
      chk("unmapped read", 64'(rd), 64'h0);
      wrap_up();
   end

   initial begin
      repeat (3000) @(posedge clk_sys);
      error_cnt++;
      wrap_up();
   end
endmodule
